// File: inc/vrss_pkg.sv
// Purpose: Shared constants, types and code decoding for the regulator soft-start sequencer.
// Assumes: 50 MHz core clock; reference levels counted in 6.25 mV steps.
// Notes: Long delays are defaults for top-level parameters so simulation can shorten them.
package vrss_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned INIT_DELAY_NS = 1360000;
  localparam int unsigned BOOT_HOLD_NS = 85000;
  localparam int unsigned READY_DELAY_NS = 85000;
  localparam int unsigned CODE_VALID_NS = 500;
  localparam int unsigned INIT_DELAY_CYC = (INIT_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BOOT_HOLD_CYC = (BOOT_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READY_DELAY_CYC = (READY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CODE_VALID_CYC = (CODE_VALID_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMER_W = 20;
  localparam int STABLE_W = 6;

  //////////////////////////////////////////////////////////////////////////////
  // Reference scale: one step is 6.25 mV
  localparam int LEVEL_W = 9;
  localparam logic [8:0] BOOT_LEVEL = 9'h0b0;
  localparam logic [8:0] CODE_LEVEL_BASE = 9'h102;
  localparam logic [7:0] CODE_FIRST_VALID = 8'h02;
  localparam logic [7:0] CODE_LAST_VALID = 8'hb2;
  localparam logic [7:0] CODE_OFF_A = 8'h00;
  localparam logic [7:0] CODE_OFF_B = 8'h01;
  localparam logic [7:0] CODE_OFF_C = 8'hfe;
  localparam logic [7:0] CODE_OFF_D = 8'hff;
  localparam int OFFSET_W = 4;
  localparam int SYNC_W = 12;
  localparam int SYNC_POR = 0;
  localparam int SYNC_PWR = 1;
  localparam int SYNC_VTT = 2;
  localparam int SYNC_OSC = 3;
  localparam int SYNC_CODE = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic valid;
    logic off;
    logic [8:0] level;
  } vrss_code_t;

  typedef struct packed {
    logic bias_ok;
    logic pwr_en;
    logic vtt_en;
  } vrss_start_t;

  typedef enum logic [2:0] {
    VRSS_SHUTDOWN,
    VRSS_INIT_DELAY,
    VRSS_BOOT_RAMP,
    VRSS_BOOT_HOLD,
    VRSS_TARGET_RAMP,
    VRSS_READY_DELAY,
    VRSS_REGULATE,
    VRSS_OFF_LATCH
  } vrss_state_t;

  // Maps an 8-bit select code to its reference level
  function automatic vrss_code_t vrss_decode(input logic [7:0] code);
    vrss_code_t r;
    r.valid = 1'b0;
    r.off = 1'b0;
    r.level = 9'h000;
    if (code == CODE_OFF_A || code == CODE_OFF_B || code == CODE_OFF_C || code == CODE_OFF_D) begin
      r.off = 1'b1;
    end else if (code >= CODE_FIRST_VALID && code <= CODE_LAST_VALID) begin
      r.valid = 1'b1;
      r.level = CODE_LEVEL_BASE - {1'b0, code};
    end
    return r;
  endfunction : vrss_decode

endpackage : vrss_pkg

// File: rtl/vrss_sync.sv
// Purpose: Two-stage synchroniser bank for inputs arriving from outside the clock domain.
// Assumes: Each bit is independent; multi-bit words are validated downstream by stability.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module vrss_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,  // Core clock
  input wire logic reset_i,  // Async reset, active high
  input wire logic [W-1:0] async_i,  // Unsynchronised inputs
  output logic [W-1:0] sync_o  // Synchronised outputs
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // One two-flop chain per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_o = sync_q;

endmodule : vrss_sync

// File: rtl/vrss_sequencer.sv
// Purpose: Startup and readiness sequencer for a multiphase core regulator controller.
// Assumes: Bias and enable comparators (with their hysteresis) are analog; their outputs arrive here as levels.
// Notes: Reference and sensed output are counted in 6.25 mV steps; offset is a static step count.
//
// What this block does
// - Phase outputs high impedance while in shutdown
// - Stay shut down until bias reset released
// - Stay shut down until power enable high
// - Termination enable also needed; all three together
// - Ramp to boot level before reading code
// - Fixed initial delay before first ramp
// - Boot hold fixed time plus code validation
// - Valid sampled code starts ramp to target
// - Off code shuts down until inputs cycle
// - Reference moves one step per oscillator period
// - Step period follows external soft-start oscillator
// - Ready asserts after fixed post-ramp delay
// - Ready low through shutdown and soft-start
// - Ready low on faults, disables, off code
// - Undervoltage below half target level (selected minus offset) pulls ready
// - Follow code changes stepwise while regulating
`timescale 1ns/1ps
module vrss_sequencer #(
  parameter int unsigned INIT_DELAY_CYC = vrss_pkg::INIT_DELAY_CYC,
  parameter int unsigned BOOT_HOLD_CYC = vrss_pkg::BOOT_HOLD_CYC,
  parameter int unsigned READY_DELAY_CYC = vrss_pkg::READY_DELAY_CYC
) (
  input wire logic clk_i,  // Core clock, 50 MHz
  input wire logic reset_i,  // Async reset, active high
  input wire logic bias_por_ok_i,  // Bias monitor above reset threshold
  input wire logic power_enable_input_i,  // Power enable comparator output
  input wire logic termination_rail_enable_i,  // Termination enable comparator output
  input wire logic soft_start_osc_i,  // Soft-start oscillator square wave
  input wire logic [7:0] voltage_select_code_i,  // Processor voltage-select code
  input wire logic [8:0] output_sense_input_i,  // Sensed output, same-domain converter result
  input wire logic overvoltage_i,  // Overvoltage detector, same domain
  input wire logic [3:0] offset_set_pin_i,  // Programmed offset in steps, static
  output logic phase_hiz_o,  // High: phase outputs held high impedance
  output logic [8:0] reference_o,  // Internal reference level
  output logic regulator_ready_output_o,  // Ready pin output value, always low
  output logic regulator_ready_oe_n_o,  // Low while ready pin is pulled low
  output logic undervoltage_o,  // Undervoltage flag
  output logic [2:0] state_o  // Sequencer state
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [vrss_pkg::SYNC_W-1:0] sync_raw;
  logic [vrss_pkg::SYNC_W-1:0] sync_val;
  vrss_pkg::vrss_start_t start_s;
  logic osc_s;
  logic [7:0] code_s;

  assign sync_raw = {voltage_select_code_i, soft_start_osc_i, termination_rail_enable_i,
                     power_enable_input_i, bias_por_ok_i};

  vrss_sync #(
    .W(vrss_pkg::SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(sync_raw),
    .sync_o(sync_val)
  );

  assign start_s.bias_ok = sync_val[vrss_pkg::SYNC_POR];
  assign start_s.pwr_en = sync_val[vrss_pkg::SYNC_PWR];
  assign start_s.vtt_en = sync_val[vrss_pkg::SYNC_VTT];
  assign osc_s = sync_val[vrss_pkg::SYNC_OSC];
  assign code_s = sync_val[vrss_pkg::SYNC_CODE +: 8];

  logic start_ok;
  assign start_ok = start_s.bias_ok & start_s.pwr_en & start_s.vtt_en;

  //////////////////////////////////////////////////////////////////////////////
  // Soft-start oscillator edge gives the step strobe
  logic osc_q;
  logic step_tick;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_s;
    end
  end

  assign step_tick = osc_s & ~osc_q;

  //////////////////////////////////////////////////////////////////////////////
  // Code validation: code must stand unchanged for the validation time
  logic [7:0] code_q;
  logic [vrss_pkg::STABLE_W-1:0] stable_q;
  logic code_stable;
  vrss_pkg::vrss_code_t dec;

  assign dec = vrss_pkg::vrss_decode(code_q);
  assign code_stable = (stable_q == vrss_pkg::STABLE_W'(vrss_pkg::CODE_VALID_CYC));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      code_q <= 8'h00;
      stable_q <= '0;
    end else begin
      code_q <= code_s;
      if (code_s != code_q) begin
        stable_q <= '0;
      end else if (!code_stable) begin
        stable_q <= stable_q + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Target level: selected level minus offset, floored at zero
  logic [8:0] target_q;
  logic [8:0] code_target;

  always_comb begin
    if (dec.level > {5'h00, offset_set_pin_i}) begin
      code_target = dec.level - {5'h00, offset_set_pin_i};
    end else begin
      code_target = 9'h000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  vrss_pkg::vrss_state_t state_q;
  logic [vrss_pkg::TIMER_W-1:0] timer_q;
  logic timer_done;
  logic ref_at_target;
  logic [8:0] ref_q;
  vrss_pkg::vrss_state_t state_prev_q;
  logic timer_live;

  assign ref_at_target = (ref_q == target_q);

  // First cycle of a state still holds the count of the state before it
  assign timer_live = (state_q == state_prev_q);

  always_comb begin
    timer_done = 1'b0;
    if (timer_live) begin
      case (state_q)
        vrss_pkg::VRSS_INIT_DELAY: timer_done = (timer_q >= vrss_pkg::TIMER_W'(INIT_DELAY_CYC - 1));
        vrss_pkg::VRSS_BOOT_HOLD: timer_done = (timer_q >= vrss_pkg::TIMER_W'(BOOT_HOLD_CYC - 1));
        vrss_pkg::VRSS_READY_DELAY: timer_done = (timer_q >= vrss_pkg::TIMER_W'(READY_DELAY_CYC - 1));
        default: timer_done = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= vrss_pkg::VRSS_SHUTDOWN;
    end else if (!start_ok) begin
      state_q <= vrss_pkg::VRSS_SHUTDOWN;
    end else begin
      case (state_q)
        vrss_pkg::VRSS_SHUTDOWN: begin
          state_q <= vrss_pkg::VRSS_INIT_DELAY;
        end
        vrss_pkg::VRSS_INIT_DELAY: begin
          if (timer_done) begin
            state_q <= vrss_pkg::VRSS_BOOT_RAMP;
          end
        end
        vrss_pkg::VRSS_BOOT_RAMP: begin
          if (ref_at_target) begin
            state_q <= vrss_pkg::VRSS_BOOT_HOLD;
          end
        end
        vrss_pkg::VRSS_BOOT_HOLD: begin
          if (timer_done && code_stable) begin
            if (dec.off) begin
              state_q <= vrss_pkg::VRSS_OFF_LATCH;
            end else if (dec.valid) begin
              state_q <= vrss_pkg::VRSS_TARGET_RAMP;
            end
          end
        end
        vrss_pkg::VRSS_TARGET_RAMP: begin
          if (ref_at_target) begin
            state_q <= vrss_pkg::VRSS_READY_DELAY;
          end
        end
        vrss_pkg::VRSS_READY_DELAY: begin
          if (timer_done) begin
            state_q <= vrss_pkg::VRSS_REGULATE;
          end
        end
        vrss_pkg::VRSS_REGULATE: begin
          if (code_stable && dec.off) begin
            state_q <= vrss_pkg::VRSS_OFF_LATCH;
          end
        end
        vrss_pkg::VRSS_OFF_LATCH: begin
          state_q <= vrss_pkg::VRSS_OFF_LATCH;
        end
        default: begin
          state_q <= vrss_pkg::VRSS_SHUTDOWN;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase timer, restarted on every state change; counts cycles spent in the state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_prev_q <= vrss_pkg::VRSS_SHUTDOWN;
      timer_q <= '0;
    end else begin
      state_prev_q <= state_q;
      if (state_q != state_prev_q) begin
        timer_q <= vrss_pkg::TIMER_W'(1);
      end else if (!timer_done) begin
        timer_q <= timer_q + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Target selection
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      target_q <= 9'h000;
    end else begin
      case (state_q)
        vrss_pkg::VRSS_INIT_DELAY, vrss_pkg::VRSS_BOOT_RAMP: begin
          target_q <= vrss_pkg::BOOT_LEVEL;
        end
        vrss_pkg::VRSS_BOOT_HOLD: begin
          if (timer_done && code_stable && dec.valid) begin
            target_q <= code_target;
          end
        end
        vrss_pkg::VRSS_REGULATE: begin
          if (code_stable && dec.valid) begin
            target_q <= code_target;
          end
        end
        vrss_pkg::VRSS_TARGET_RAMP, vrss_pkg::VRSS_READY_DELAY: begin
          target_q <= target_q;
        end
        default: begin
          target_q <= 9'h000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference stepping, one step per oscillator period
  logic ramping;
  assign ramping = (state_q == vrss_pkg::VRSS_BOOT_RAMP) || (state_q == vrss_pkg::VRSS_TARGET_RAMP)
                || (state_q == vrss_pkg::VRSS_REGULATE);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_q <= 9'h000;
    end else if (state_q == vrss_pkg::VRSS_SHUTDOWN || state_q == vrss_pkg::VRSS_OFF_LATCH
                 || state_q == vrss_pkg::VRSS_INIT_DELAY) begin
      ref_q <= 9'h000;
    end else if (ramping && step_tick && !ref_at_target) begin
      if (ref_q < target_q) begin
        ref_q <= ref_q + 1'b1;
      end else begin
        ref_q <= ref_q - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Undervoltage monitor against half the target level (selected level minus offset)
  logic uv_q;
  logic live;
  assign live = (state_q == vrss_pkg::VRSS_READY_DELAY) || (state_q == vrss_pkg::VRSS_REGULATE);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_q <= 1'b0;
    end else begin
      uv_q <= live && (output_sense_input_i < {1'b0, target_q[8:1]});
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers
  logic hiz_q;
  logic ready_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hiz_q <= 1'b1;
    end else begin
      hiz_q <= (state_q == vrss_pkg::VRSS_SHUTDOWN) || (state_q == vrss_pkg::VRSS_OFF_LATCH)
            || (state_q == vrss_pkg::VRSS_INIT_DELAY) || !start_ok;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_q == vrss_pkg::VRSS_REGULATE) && start_ok
              && !(code_stable && dec.off) && !uv_q && !overvoltage_i;
    end
  end

  assign phase_hiz_o = hiz_q;
  assign reference_o = ref_q;
  assign regulator_ready_output_o = 1'b0;
  assign regulator_ready_oe_n_o = ready_q;
  assign undervoltage_o = uv_q;
  assign state_o = state_q;

endmodule : vrss_sequencer

// File: testbench/vrss_seq_properties.sv
// Purpose: Port-level timing checks for the soft-start sequencer.
// Assumes: State codes follow vrss_pkg::vrss_state_t order.
// Notes: Bound into every vrss_sequencer instance.
`timescale 1ns/1ps
module vrss_seq_properties #(
  parameter int unsigned INIT_DELAY_CYC = 20,
  parameter int unsigned BOOT_HOLD_CYC = 20,
  parameter int unsigned READY_DELAY_CYC = 20
) (
  input wire logic clk_i,  // Clock
  input wire logic reset_i,  // Reset
  input wire logic bias_por_ok_i,  // Bias ok
  input wire logic power_enable_input_i,  // Power enable
  input wire logic termination_rail_enable_i,  // Rail enable
  input wire logic soft_start_osc_i,  // Step clock
  input wire logic overvoltage_i,  // Overvoltage
  input wire logic phase_hiz_o,  // Phases released
  input wire logic [8:0] reference_o,  // Reference
  input wire logic regulator_ready_oe_n_o,  // Ready pull-down
  input wire logic [2:0] state_o  // State
);
  logic [2:0] prev_q;
  logic [19:0] run_q;
  logic [3:0] osc_age_q;

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current state and age of the last step clock rise
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_q <= 3'h0;
      run_q <= 20'h00000;
    end else begin
      prev_q <= state_o;
      run_q <= (state_o == prev_q) ? run_q + 20'h00001 : 20'h00001;
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) osc_age_q <= 4'hf;
    else if ($rose(soft_start_osc_i)) osc_age_q <= 4'h0;
    else if (osc_age_q != 4'hf) osc_age_q <= osc_age_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_shutdown_hiz: assert property (state_o == 3'h0 |-> phase_hiz_o)
    else $error("phases driven in shutdown");
  a_start_needs_all: assert property ((!bias_por_ok_i || !power_enable_input_i || !termination_rail_enable_i) [*4] |-> state_o == 3'h0)
    else $error("running without all start conditions");
  a_ready_held_low: assert property (state_o != 3'h6 |=> !regulator_ready_oe_n_o)
    else $error("ready released outside regulation");
  a_ov_drops_ready: assert property (overvoltage_i |=> !regulator_ready_oe_n_o)
    else $error("ready released during overvoltage");
  a_init_length: assert property (prev_q == 3'h1 && state_o == 3'h2 |-> run_q >= INIT_DELAY_CYC && run_q <= INIT_DELAY_CYC + 1)
    else $error("initial delay length wrong");
  a_boot_level: assert property (state_o == 3'h3 |-> reference_o == vrss_pkg::BOOT_LEVEL)
    else $error("boot hold not at boot level");
  a_hold_min: assert property (prev_q == 3'h3 && state_o inside {3'h4, 3'h7} |-> run_q >= BOOT_HOLD_CYC)
    else $error("boot hold too short");
  a_ready_length: assert property (prev_q == 3'h5 && state_o == 3'h6 |-> run_q >= READY_DELAY_CYC && run_q <= READY_DELAY_CYC + 1)
    else $error("ready delay length wrong");
  a_ramp_unit: assert property (state_o inside {3'h2, 3'h4, 3'h6} && prev_q == state_o && $changed(reference_o) |-> reference_o - $past(reference_o) == 9'h001 || $past(reference_o) - reference_o == 9'h001)
    else $error("reference moved more than one step");
  a_step_on_osc: assert property (state_o == 3'h2 && prev_q == 3'h2 && $changed(reference_o) |-> osc_age_q inside {[4'h1:4'h5]})
    else $error("reference step not tied to step clock");
endmodule : vrss_seq_properties

bind vrss_sequencer vrss_seq_properties #(.INIT_DELAY_CYC(INIT_DELAY_CYC), .BOOT_HOLD_CYC(BOOT_HOLD_CYC),
  .READY_DELAY_CYC(READY_DELAY_CYC)) u_props (.clk_i, .reset_i, .bias_por_ok_i, .power_enable_input_i,
  .termination_rail_enable_i, .soft_start_osc_i, .overvoltage_i, .phase_hiz_o, .reference_o,
  .regulator_ready_oe_n_o, .state_o);

// File: testbench/vrss_far_model.sv
// Purpose: Processor, step oscillator and power stage seen from the sequencer.
// Assumes: Power stage output tracks the reference when phases are driven.
// Notes: Droop makes the output sag to a quarter of the reference.
`timescale 1ns/1ps
module vrss_far_model (
  input wire logic clk_i,  // Clock
  input wire logic [7:0] code_req_i,  // Code the processor aims for
  input wire logic slew_i,  // High: one code step per interval
  input wire logic droop_i,  // High: output sags
  input wire logic phase_hiz_i,  // Phases released
  input wire logic [8:0] reference_i,  // Reference to follow
  output logic soft_start_osc_o,  // Step clock, period 8 cycles
  output logic [7:0] code_o,  // Select code
  output logic [8:0] sense_o  // Sensed output
);
  logic [5:0] tick_q = 6'h00;
  initial soft_start_osc_o = 1'b0;
  initial code_o = 8'h00;
  always @(negedge clk_i) begin
    tick_q <= tick_q + 6'h01;
    if (tick_q[1:0] == 2'h3) soft_start_osc_o <= ~soft_start_osc_o;
    if (!slew_i) code_o <= code_req_i;
    else if (tick_q == 6'h3f && code_o < code_req_i) code_o <= code_o + 8'h01;
    else if (tick_q == 6'h3f && code_o > code_req_i) code_o <= code_o - 8'h01;
  end
  assign sense_o = phase_hiz_i ? 9'h000 : (droop_i ? reference_i >> 2 : reference_i);
endmodule : vrss_far_model

// File: testbench/test_vr_softstart_sequencer.sv
// Purpose: Start, regulate, fault and shutdown sequences of the sequencer.
// Assumes: Offset fixed at four steps; short delay parameters.
// Notes: Inputs change on the falling edge, outputs read 1 ns after rising.
`timescale 1ns/1ps
module test_vr_softstart_sequencer;
  localparam int unsigned N = 20;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic bias = 1'b0, pwr = 1'b0, vtt = 1'b0, ov = 1'b0, slew = 1'b0, droop = 1'b0;
  logic [7:0] code_req = 8'h3a;
  logic [7:0] off_codes [4] = '{8'h00, 8'h01, 8'hfe, 8'hff};
  logic osc, hiz, rdy, oe_n, uv;
  logic [7:0] code;
  logic [8:0] sense, ref_l;
  logic [2:0] st;
  int mismatches = 0, checks = 0, n;
  always #10 clk_i = ~clk_i;

  vrss_sequencer #(.INIT_DELAY_CYC(N), .BOOT_HOLD_CYC(N), .READY_DELAY_CYC(N)) dut (.clk_i, .reset_i,
    .bias_por_ok_i(bias), .power_enable_input_i(pwr), .termination_rail_enable_i(vtt), .soft_start_osc_i(osc),
    .voltage_select_code_i(code), .output_sense_input_i(sense), .overvoltage_i(ov), .offset_set_pin_i(4'h4),
    .phase_hiz_o(hiz), .reference_o(ref_l), .regulator_ready_output_o(rdy), .regulator_ready_oe_n_o(oe_n),
    .undervoltage_o(uv), .state_o(st));
  vrss_far_model far (.clk_i, .code_req_i(code_req), .slew_i(slew), .droop_i(droop), .phase_hiz_i(hiz),
    .reference_i(ref_l), .soft_start_osc_o(osc), .code_o(code), .sense_o(sense));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_word(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({8'h00, got}, {8'h00, exp});
  endtask : cmp_bit
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wait_state(input logic [2:0] s, input int bound, output int cnt);
    cnt = 0;
    while (st !== s) begin
      tick(1);
      cnt++;
      if (cnt > bound) begin
        cmp_word({6'h00, st}, {6'h00, s});
        tally_and_finish();
      end
    end
  endtask : wait_state

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    // Any two of the three start conditions keep it shut down
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_i);
      {bias, pwr, vtt} = 3'h7 ^ (3'h1 << i);
      tick(8);
      cmp_word({6'h00, st}, 9'h000);
      cmp_bit(hiz, 1'b1);
      cmp_bit(oe_n, 1'b0);
    end
    @(negedge clk_i);
    {bias, pwr, vtt} = 3'h7;
    wait_state(3'h1, 8, n);
    wait_state(3'h2, N + 4, n);
    cmp_bit(n >= N && n <= N + 1, 1'b1);
    wait_state(3'h3, 3000, n);
    cmp_bit(n >= 176 * 8 - 8 && n <= 176 * 8 + 8, 1'b1);
    cmp_word(ref_l, 9'h0b0);
    cmp_bit(oe_n, 1'b0);
    wait_state(3'h4, N + 40, n);
    cmp_bit(n >= N, 1'b1);
    wait_state(3'h5, 400, n);
    cmp_word(ref_l, 9'h102 - 9'h03a - 9'h004);
    wait_state(3'h6, N + 4, n);
    cmp_bit(n >= N && n <= N + 1, 1'b1);
    tick(2);
    cmp_bit(oe_n, 1'b1);
    cmp_bit(rdy, 1'b0);
    // Sag below half, then overvoltage
    @(negedge clk_i);
    droop = 1'b1;
    tick(4);
    cmp_bit(uv, 1'b1);
    cmp_bit(oe_n, 1'b0);
    @(negedge clk_i);
    droop = 1'b0;
    ov = 1'b1;
    tick(4);
    cmp_bit(uv, 1'b0);
    cmp_bit(oe_n, 1'b0);
    @(negedge clk_i);
    ov = 1'b0;
    tick(4);
    cmp_bit(oe_n, 1'b1);
    // Code walks while regulating, last into the ignored range
    @(negedge clk_i);
    slew = 1'b1;
    code_req = 8'h36;
    tick(6 * 64);
    cmp_word(ref_l, 9'h102 - 9'h036 - 9'h004);
    cmp_bit(oe_n, 1'b1);
    @(negedge clk_i);
    code_req = 8'hc0;
    tick(140 * 64);
    cmp_word(ref_l, 9'h102 - 9'h0b2 - 9'h004);
    cmp_word({6'h00, st}, 9'h006);
    // Drop a start condition, restart onto each off code
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      slew = 1'b0;
      {bias, pwr, vtt} = 3'h7 ^ (3'h1 << (i % 3));
      code_req = off_codes[i];
      tick(6);
      cmp_word({6'h00, st}, 9'h000);
      cmp_bit(hiz, 1'b1);
      cmp_bit(oe_n, 1'b0);
      @(negedge clk_i);
      {bias, pwr, vtt} = 3'h7;
      wait_state(3'h1, 8, n);
      wait_state(3'h7, 3100, n);
      tick(1);
      cmp_bit(hiz, 1'b1);
      cmp_bit(oe_n, 1'b0);
      tick(50);
      cmp_word({6'h00, st}, 9'h007);
    end
    tally_and_finish();
  end
endmodule : test_vr_softstart_sequencer
